// File: bench/afe_model.sv
// Behavioural output pins and comparators of both channels.
// Assumes fault kinds from the bench: 0 none, 1 open load, 2 short to battery.
`timescale 1ns/1ns
module afe_model (
    input wire logic i_core_clk,
    input wire logic [3:0] i_fault,
    input wire logic [1:0] i_pullup_en,
    input wire logic [1:0] i_comp_en,
    output logic [1:0] o_comp_high
);
    logic [1:0] junk_q = 2'h0;
    logic [1:0] pin_high;
    // An open output only rises while the pull-up source feeds it
    assign pin_high[0] = (i_fault[1:0] == 2'h2) || (i_fault[1:0] == 2'h1 && i_pullup_en[0]);
    assign pin_high[1] = (i_fault[3:2] == 2'h2) || (i_fault[3:2] == 2'h1 && i_pullup_en[1]);
    // A disabled comparator gives no usable level, so it toggles
    always_ff @(posedge i_core_clk) begin
        junk_q <= ~junk_q;
    end
    assign o_comp_high = (i_comp_en & pin_high) | (~i_comp_en & junk_q);
endmodule

// File: bench/diag_checker.sv
// Port assertions for the supply and off-state diagnostics top.
// Assumes the register strobes are driven from the core clock.
`timescale 1ns/1ns
module diag_checker (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [1:0] i_wp_loop_active,
    input wire logic [1:0] i_below_entry,
    input wire logic [15:0] o_rdata,
    input wire logic o_supply_conv_en,
    input wire logic o_pullup_en_ch0,
    input wire logic [1:0] o_pulldown_en,
    input wire logic [1:0] o_comp_en,
    input wire logic [1:0] o_low_ratio
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
        else $error("read data not zero outside a read");
    AST_CONV_LOOP: assert property ((|i_wp_loop_active)[*2] |-> !o_supply_conv_en)
        else $error("supply conversion runs during loop");
    AST_READY_LOOP: assert property ((|i_wp_loop_active)[*2] ##0
        (i_rd && i_addr == diag_pkg::REG_SUPPLY_RESULT) |=> !o_rdata[diag_pkg::BIT_SUPPLY_RDY])
        else $error("ready set during loop");
    // Leaving the loop reaches the enable output three edges later
    AST_CONV_CAUSE: assert property ($rose(o_supply_conv_en) |->
        $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3) || $past(|i_wp_loop_active)
        || $past(|i_wp_loop_active, 2) || $past(|i_wp_loop_active, 3))
        else $error("conversion started without cause");
    AST_PU_COMP: assert property (o_pullup_en_ch0 |-> o_comp_en[0])
        else $error("pull-up without comparator");
    AST_PD_COMP: assert property (o_pulldown_en[1] |-> o_comp_en[1])
        else $error("pull-down without comparator");
    AST_PU_PD_EXCL: assert property (!(o_pullup_en_ch0 && o_pulldown_en[0]))
        else $error("pull-up and pull-down together");
    AST_LOW_ENTRY: assert property ($rose(o_low_ratio[0]) |-> $past(i_below_entry[0]))
        else $error("low ratio entered above threshold");
endmodule
bind supply_offstate_diag diag_checker chk (.i_core_clk, .i_nrst, .i_addr, .i_wr, .i_rd,
    .i_wp_loop_active, .i_below_entry, .o_rdata, .o_supply_conv_en, .o_pullup_en_ch0,
    .o_pulldown_en, .o_comp_en, .o_low_ratio);

// File: bench/testbench.sv
// Register-port testbench for the supply and off-state diagnostics.
// Assumes blanking shortened to 20 cycles and a 500-cycle conversion interval.
`timescale 1ns/1ns
module testbench;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_addr = 8'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [9:0] i_supply_sample = 10'h2a5;
    logic [1:0] i_wp_loop_active = 2'h0;
    logic [1:0] i_below_entry = 2'h0;
    logic [1:0] i_comp_high;
    logic [3:0] fault = 4'h0;
    logic [15:0] o_rdata;
    logic o_supply_conv_en, o_pullup_en_ch0, o_pullup_en_ch1;
    logic [1:0] o_pullup_str_ch0, o_pullup_str_ch1, o_pulldown_en, o_comp_en, o_low_ratio, o_gain8;
    logic [15:0] got;
    logic pu, pd, opn, sht;
    int errors = 0;
    int total_checks = 0;

    supply_offstate_diag #(.BLANK_CYC_MAX(32'h14)) dut (.i_core_clk, .i_nrst, .i_addr,
        .i_wdata, .i_wr, .i_rd, .i_supply_sample, .i_wp_loop_active, .i_comp_high,
        .i_below_entry, .o_rdata, .o_supply_conv_en, .o_pullup_en_ch0, .o_pullup_en_ch1,
        .o_pullup_str_ch0, .o_pullup_str_ch1, .o_pulldown_en, .o_comp_en, .o_low_ratio,
        .o_gain8);
    afe_model afe (.i_core_clk, .i_fault(fault), .i_pullup_en({o_pullup_en_ch1, o_pullup_en_ch0}),
        .i_comp_en(o_comp_en), .o_comp_high(i_comp_high));

    initial begin
        forever #10 i_core_clk = ~i_core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Returns two edges after the strobe so registered outputs have settled
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 got = o_rdata;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #1000000;
        errors++;
        $display("BAD t=%0t run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rd(diag_pkg::REG_ADC_CONFIG);
        check(got, 16'h1);
        rd(diag_pkg::REG_SUPPLY_RESULT);
        check(got, 16'h0);
        rd(8'h3f);
        check(got, 16'h0);
        wr(8'h3f, 16'h0);
        check(16'(o_supply_conv_en), 16'h0);
        wr(diag_pkg::REG_ADC_CONFIG, 16'h0);
        repeat (600) @(posedge i_core_clk);
        rd(diag_pkg::REG_SUPPLY_RESULT);
        check(got, 16'h82a5);
        rd(diag_pkg::REG_SUPPLY_RESULT);
        check(got, 16'h02a5);
        @(posedge i_core_clk);
        i_wp_loop_active <= 2'h2;
        i_supply_sample <= 10'h155;
        repeat (600) @(posedge i_core_clk);
        check(16'(o_supply_conv_en), 16'h0);
        rd(diag_pkg::REG_SUPPLY_RESULT);
        check(16'(got[15]), 16'h0);
        i_wp_loop_active <= 2'h0;
        repeat (600) @(posedge i_core_clk);
        check(16'(o_supply_conv_en), 16'h1);
        rd(diag_pkg::REG_SUPPLY_RESULT);
        check(got, 16'h8155);
        wr(diag_pkg::REG_ADC_CONFIG, 16'h1);
        check(16'(o_supply_conv_en), 16'h0);
        $display("supply test done");
        for (int c = 0; c < 2; c++) begin
            wr(diag_pkg::REG_CH_SETUP0 + 8'(c), 16'h1);
            check(16'(o_low_ratio[c]), 16'h0);
            wr(diag_pkg::REG_CH_SETUP0 + 8'(c), 16'h0);
            i_below_entry[c] <= 1'b1;
            wr(diag_pkg::REG_CH_SETUP0 + 8'(c), 16'h3);
            check(16'({o_gain8[c], o_low_ratio[c]}), 16'h3);
            rd(diag_pkg::REG_FAULT_STAT0 + 8'(c));
            check(got & 16'hc, 16'hc);
            wr(diag_pkg::REG_CH_SETUP0 + 8'(c), 16'h0);
            check(16'({o_gain8[c], o_low_ratio[c]}), 16'h0);
        end
        $display("sense test done");
        for (int m = 0; m < 4; m++) begin
            for (int f = 1; f < 3; f++) begin
                pu = (m == 2);
                pd = (m == 1);
                opn = pu;
                sht = pd && f == 2;
                @(posedge i_core_clk);
                fault <= 4'(f);
                wr(diag_pkg::REG_CH_SETUP0, 16'h00f0 | 16'(m << diag_pkg::LSB_MODE));
                check(16'({o_pullup_en_ch0, o_pulldown_en[0], o_comp_en[0]}),
                    16'({pu, pd, pu | pd}));
                if (pu)
                    check(16'(o_pullup_str_ch0), 16'h3);
                rd(diag_pkg::REG_FAULT_STAT0);
                check(got & 16'h3, 16'h0);
                repeat (25) @(posedge i_core_clk);
                rd(diag_pkg::REG_FAULT_STAT0);
                check(got & 16'h3, 16'({sht, opn}));
                fault <= 4'h0;
                rd(diag_pkg::REG_FAULT_STAT0);
                check(got & 16'h3, 16'({sht, opn}));
                rd(diag_pkg::REG_FAULT_STAT0);
                check(got & 16'h3, 16'h0);
                wr(diag_pkg::REG_CH_SETUP0, 16'h0);
            end
        end
        $display("off-state test done");
        for (int m = 1; m < 3; m++) begin
            pu = (m == 2);
            pd = (m == 1);
            wr(diag_pkg::REG_CH_SETUP1, 16'h0020 | 16'(m << diag_pkg::LSB_MODE));
            check(16'(o_pullup_str_ch1), 16'h2);
            check(16'({o_pullup_en_ch1, o_pulldown_en[1], o_comp_en[1]}), 16'({pu, pd, 1'b1}));
            wr(diag_pkg::REG_SW_STATE, 16'h2);
            check(16'({o_pullup_en_ch1, o_pulldown_en[1], o_comp_en[1]}), 16'h0);
            wr(diag_pkg::REG_SW_STATE, 16'h0);
            check(16'({o_pullup_en_ch1, o_pulldown_en[1], o_comp_en[1]}), 16'({pu, pd, 1'b1}));
            wr(diag_pkg::REG_CH_SETUP1, 16'h0);
        end
        $display("switch state test done");
        summarize();
    end
endmodule

// File: hw/diag_pkg.sv
// Constants, register map and carrier types for the supply and off-state load diagnostics.
// Assumes a single 50 MHz core clock and a simple strobe register port.
package diag_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned ADC_W = 10;

    // Register indices (i_addr is compared with the index directly)
    localparam logic [7:0] REG_ADC_CONFIG = 8'h00;
    localparam logic [7:0] REG_SUPPLY_RESULT = 8'h01;
    localparam logic [7:0] REG_CH_SETUP0 = 8'h02;
    localparam logic [7:0] REG_CH_SETUP1 = 8'h03;
    localparam logic [7:0] REG_FAULT_STAT0 = 8'h04;
    localparam logic [7:0] REG_FAULT_STAT1 = 8'h05;
    localparam logic [7:0] REG_SW_STATE = 8'h06;

    // ADC config fields
    localparam int unsigned BIT_SUPPLY_DIS = 0;
    localparam logic ADC_CONFIG_RST = 1'b1;
    // Supply result fields
    localparam int unsigned BIT_SUPPLY_RDY = 15;
    // Channel setup fields
    localparam int unsigned BIT_LOW_SENSE = 0;
    localparam int unsigned BIT_GAIN_SEL = 1;
    localparam int unsigned LSB_MODE = 2;
    localparam int unsigned LSB_PU_STR = 4;
    localparam int unsigned LSB_BLANK = 6;
    localparam int unsigned BIT_WP_EN = 8;
    // Fault status fields
    localparam int unsigned BIT_OPEN_FLAG = 0;
    localparam int unsigned BIT_SHORT_FLAG = 1;
    localparam int unsigned BIT_LOW_EFF = 2;
    localparam int unsigned BIT_GAIN_EFF = 3;

    localparam logic [1:0] MODE_PULLUP = 2'h2;
    localparam logic [1:0] MODE_PULLDOWN = 2'h1;

    // Sense ratios
    localparam int unsigned RATIO_NOMINAL = 5000;
    localparam int unsigned RATIO_LOW = 1400;
    localparam int unsigned SENSE_GAIN = 8;

    // Blanking times in microseconds per select code, and conversion interval
    localparam int unsigned BLANK_US0 = 100;
    localparam int unsigned BLANK_US1 = 200;
    localparam int unsigned BLANK_US2 = 500;
    localparam int unsigned BLANK_US3 = 1000;
    localparam int unsigned CONV_US = 10;
    localparam int unsigned CONV_CYC = CONV_US * (CLK_HZ / 1000000);
    localparam logic [31:0] BLANK_CYC_DEF = 32'(BLANK_US3 * (CLK_HZ / 1000000));

    typedef struct packed {
        logic wp_enable;
        logic [1:0] blank_sel;
        logic [1:0] pu_str;
        logic [1:0] mode;
        logic gain_sel;
        logic low_sense;
    } ch_setup_s;

    typedef struct packed {
        logic pullup_en;
        logic [1:0] pullup_str;
        logic pulldown_en;
        logic comp_en;
        logic low_ratio;
        logic gain8;
    } ch_analog_s;
endpackage

// File: hw/offstate_chan.sv
// One channel of off-state open-load / battery-short detection plus sense ratio control.
// Assumes comparator and current threshold inputs are synchronous to i_core_clk.
`timescale 1ns/1ns
module offstate_chan #(
    parameter logic [31:0] BLANK_CYC_MAX = diag_pkg::BLANK_CYC_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire diag_pkg::ch_setup_s i_setup,
    input wire logic i_ch_on,
    input wire logic i_comp_high,
    input wire logic i_below_entry,
    input wire logic i_fault_read,
    output diag_pkg::ch_analog_s o_analog,
    output logic o_open_flag,
    output logic o_short_flag
);
    logic detect_on;
    logic pullup_mode;
    logic pulldown_mode;
    logic [31:0] blank_q;
    logic [31:0] blank_target;
    logic judged;

    function automatic logic [31:0] blank_cycles(input logic [1:0] sel);
        logic [31:0] us;
        us = 32'(diag_pkg::BLANK_US3);
        case (sel)
            2'h0: us = 32'(diag_pkg::BLANK_US0);
            2'h1: us = 32'(diag_pkg::BLANK_US1);
            2'h2: us = 32'(diag_pkg::BLANK_US2);
            default: us = 32'(diag_pkg::BLANK_US3);
        endcase
        return us * 32'(diag_pkg::CLK_HZ / 1000000);
    endfunction

    assign pullup_mode = (i_setup.mode == diag_pkg::MODE_PULLUP);
    assign pulldown_mode = (i_setup.mode == diag_pkg::MODE_PULLDOWN);
    // Circuitry only while the FET is off; other codes keep everything off
    assign detect_on = (pullup_mode || pulldown_mode) && !i_ch_on;
    // Long selections saturate at the parameter so simulation can shorten them
    assign blank_target = (blank_cycles(i_setup.blank_sel) > BLANK_CYC_MAX) ?
        BLANK_CYC_MAX : blank_cycles(i_setup.blank_sel);
    assign judged = detect_on && (blank_q >= blank_target) && i_comp_high;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blank_q <= 32'h0;
        end else if (!detect_on) begin
            blank_q <= 32'h0;
        end else if (blank_q < blank_target) begin
            blank_q <= blank_q + 32'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_analog <= '0;
        end else begin
            o_analog.pullup_en <= pullup_mode && !i_ch_on;
            o_analog.pullup_str <= i_setup.pu_str;
            o_analog.pulldown_en <= pulldown_mode && !i_ch_on;
            o_analog.comp_en <= detect_on;
            // Low ratio entered only below threshold; kept until software clears
            if (!i_setup.low_sense) begin
                o_analog.low_ratio <= 1'b0;
            end else if (i_below_entry) begin
                o_analog.low_ratio <= 1'b1;
            end
            o_analog.gain8 <= i_setup.gain_sel;
        end
    end

    // Set wins over the read clear; clear only when condition has gone
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_open_flag <= 1'b0;
        end else if (judged && pullup_mode) begin
            o_open_flag <= 1'b1;
        end else if (i_fault_read && !(detect_on && pullup_mode && i_comp_high)) begin
            o_open_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_short_flag <= 1'b0;
        end else if (judged && pulldown_mode) begin
            o_short_flag <= 1'b1;
        end else if (i_fault_read && !(detect_on && pulldown_mode && i_comp_high)) begin
            o_short_flag <= 1'b0;
        end
    end
endmodule

// File: hw/supply_offstate_diag.sv
// Top of the supply measurement and off-state load diagnostics with its register port.
// Assumes the converter sample and comparator inputs are synchronous to i_core_clk.
`timescale 1ns/1ns
// Operation
// - Supply conversion only when software enables it
// - Fresh result stored, ready set until read
// - Wire-protect loop suspends measurement, ready held low
// - Measurement resumes after loop if still enabled
// - Low sense bit selects ratio 1400
// - Low ratio honoured only below entry threshold
// - Gain bit scales sense voltage by eight
// - Mode 10 enables pull-up and comparator
// - Pull-up strength selectable per channel
// - Blanking time selectable per channel
// - Mode 10 sets open flag on fault
// - Open flag read-clears only when condition gone
// - Pull-up off while on, back when off
// - Mode 01 enables pull-down and comparator
// - Mode 01 reports battery short only
// - Short flag read-clears only when fault gone
// - Pull-down off while on, back when off
module supply_offstate_diag #(
    parameter logic [31:0] BLANK_CYC_MAX = diag_pkg::BLANK_CYC_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [diag_pkg::ADC_W-1:0] i_supply_sample,
    input wire logic [1:0] i_wp_loop_active,
    input wire logic [1:0] i_comp_high,
    input wire logic [1:0] i_below_entry,
    output logic [15:0] o_rdata,
    output logic o_supply_conv_en,
    output logic o_pullup_en_ch0,
    output logic o_pullup_en_ch1,
    output logic [1:0] o_pullup_str_ch0,
    output logic [1:0] o_pullup_str_ch1,
    output logic [1:0] o_pulldown_en,
    output logic [1:0] o_comp_en,
    output logic [1:0] o_low_ratio,
    output logic [1:0] o_gain8
);
    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_CONV = 3'h2,
        ST_HOLD = 3'h4
    } supply_st_e;

    supply_st_e st_q;
    logic supply_dis_q;
    diag_pkg::ch_setup_s setup_q [2];
    logic [1:0] ch_on_q;
    logic [diag_pkg::ADC_W-1:0] supply_result_reg_q;
    logic supply_result_ready_q;
    logic [15:0] conv_cnt_q;
    logic conv_done;
    logic loop_any;
    logic [1:0] fault_read;
    diag_pkg::ch_analog_s analog [2];
    logic [1:0] open_flag;
    logic [1:0] short_flag;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        return a == idx;
    endfunction

    assign loop_any = |i_wp_loop_active;
    assign conv_done = (st_q == ST_CONV) &&
        (conv_cnt_q == 16'(diag_pkg::CONV_CYC - 1));
    assign fault_read[0] = i_rd && hit(i_addr, diag_pkg::REG_FAULT_STAT0);
    assign fault_read[1] = i_rd && hit(i_addr, diag_pkg::REG_FAULT_STAT1);

    // Register writes
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            supply_dis_q <= diag_pkg::ADC_CONFIG_RST;
            setup_q[0] <= '0;
            setup_q[1] <= '0;
            ch_on_q <= 2'h0;
        end else if (i_wr) begin
            if (hit(i_addr, diag_pkg::REG_ADC_CONFIG)) begin
                supply_dis_q <= i_wdata[diag_pkg::BIT_SUPPLY_DIS];
            end
            if (hit(i_addr, diag_pkg::REG_CH_SETUP0)) begin
                setup_q[0] <= i_wdata[8:0];
            end
            if (hit(i_addr, diag_pkg::REG_CH_SETUP1)) begin
                setup_q[1] <= i_wdata[8:0];
            end
            if (hit(i_addr, diag_pkg::REG_SW_STATE)) begin
                ch_on_q <= i_wdata[1:0];
            end
        end
    end

    // Supply measurement sequencer
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_OFF;
        end else begin
            case (st_q)
                ST_OFF: begin
                    if (!supply_dis_q) begin
                        st_q <= loop_any ? ST_HOLD : ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (supply_dis_q) begin
                        st_q <= ST_OFF;
                    end else if (loop_any) begin
                        st_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (supply_dis_q) begin
                        st_q <= ST_OFF;
                    end else if (!loop_any) begin
                        st_q <= ST_CONV;
                    end
                end
                default: st_q <= ST_OFF;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            conv_cnt_q <= 16'h0;
        end else if (st_q != ST_CONV || conv_done) begin
            conv_cnt_q <= 16'h0;
        end else begin
            conv_cnt_q <= conv_cnt_q + 16'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_supply_conv_en <= 1'b0;
        end else begin
            o_supply_conv_en <= (st_q == ST_CONV) && !loop_any;
        end
    end

    // Result and ready; a new result in the read cycle keeps ready set
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            supply_result_reg_q <= '0;
            supply_result_ready_q <= 1'b0;
        end else if (loop_any || st_q == ST_HOLD) begin
            supply_result_ready_q <= 1'b0;
        end else if (conv_done) begin
            supply_result_reg_q <= i_supply_sample;
            supply_result_ready_q <= 1'b1;
        end else if (i_rd && hit(i_addr, diag_pkg::REG_SUPPLY_RESULT)) begin
            supply_result_ready_q <= 1'b0;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_ch
        offstate_chan #(
            .BLANK_CYC_MAX(BLANK_CYC_MAX)
        ) u_chan (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_setup(setup_q[c]),
            .i_ch_on(ch_on_q[c]),
            .i_comp_high(i_comp_high[c]),
            .i_below_entry(i_below_entry[c]),
            .i_fault_read(fault_read[c]),
            .o_analog(analog[c]),
            .o_open_flag(open_flag[c]),
            .o_short_flag(short_flag[c])
        );
        assign o_pulldown_en[c] = analog[c].pulldown_en;
        assign o_comp_en[c] = analog[c].comp_en;
        assign o_low_ratio[c] = analog[c].low_ratio;
        assign o_gain8[c] = analog[c].gain8;
    end

    assign o_pullup_en_ch0 = analog[0].pullup_en;
    assign o_pullup_en_ch1 = analog[1].pullup_en;
    assign o_pullup_str_ch0 = analog[0].pullup_str;
    assign o_pullup_str_ch1 = analog[1].pullup_str;

    function automatic logic [15:0] fault_word(input logic o, input logic s,
                                               input logic l, input logic g);
        logic [15:0] w;
        w = 16'h0;
        w[diag_pkg::BIT_OPEN_FLAG] = o;
        w[diag_pkg::BIT_SHORT_FLAG] = s;
        w[diag_pkg::BIT_LOW_EFF] = l;
        w[diag_pkg::BIT_GAIN_EFF] = g;
        return w;
    endfunction

    // Read data valid the cycle after the strobe only; unmapped reads return zero
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 16'h0;
        end else if (!i_rd) begin
            o_rdata <= 16'h0;
        end else begin
            case (i_addr)
                diag_pkg::REG_ADC_CONFIG: o_rdata <= {15'h0, supply_dis_q};
                diag_pkg::REG_SUPPLY_RESULT: begin
                    o_rdata <= 16'h0;
                    o_rdata[diag_pkg::ADC_W-1:0] <= supply_result_reg_q;
                    o_rdata[diag_pkg::BIT_SUPPLY_RDY] <= supply_result_ready_q;
                end
                diag_pkg::REG_CH_SETUP0: o_rdata <= {7'h0, setup_q[0]};
                diag_pkg::REG_CH_SETUP1: o_rdata <= {7'h0, setup_q[1]};
                diag_pkg::REG_FAULT_STAT0: o_rdata <= fault_word(open_flag[0],
                    short_flag[0], analog[0].low_ratio, analog[0].gain8);
                diag_pkg::REG_FAULT_STAT1: o_rdata <= fault_word(open_flag[1],
                    short_flag[1], analog[1].low_ratio, analog[1].gain8);
                diag_pkg::REG_SW_STATE: o_rdata <= {14'h0, ch_on_q};
                default: o_rdata <= 16'h0;
            endcase
        end
    end
endmodule
